// [shared/bbe_regs.vh]
// Constants for the branch, bit-clear and AND execution slice
`ifndef BBE_REGS_VH
`define BBE_REGS_VH
// Opcode patterns (upper bits of the 16-bit word)
`define BBE_OP_BR_CARRY 8'hE2
`define BBE_OP_BR_NEG 8'hE6
`define BBE_OP_BIT_CLEAR 4'h9
`define BBE_OP_AND_FILE 6'h05
// Field positions
`define BBE_F_TOP4_HI 15
`define BBE_F_TOP4_LO 12
`define BBE_F_BIT_HI 11
`define BBE_F_BIT_LO 9
`define BBE_F_ACCESS 8
`define BBE_F_DEST 9
// Indexed literal offset limit
`define BBE_ILO_LIMIT 8'h5F
// Base of bank fifteen; ORed with f from 80h it gives the upper access-bank half (SFR area)
`define BBE_ACC_SFR_BASE 12'hF00
// Phase codes
`define BBE_Q1 2'h0
`define BBE_Q2 2'h1
`define BBE_Q3 2'h2
`define BBE_Q4 2'h3
// Program counter step of one word
`define BBE_PC_STEP 21'h000002
`endif

// [logic/bbe_addr_gen.v]
// File-register address generation for byte and bit instructions
`timescale 1ns/1ps
`include "bbe_regs.vh"
module bbe_addr_gen
(
  input wire [7:0] file_addr,
  input wire access_sel,
  input wire [5:0] bank_select_register,
  input wire ext_set_en,
  input wire [11:0] index_base,
  output reg [11:0] data_addr,
  output reg indexed_mode
);
  // Pick bank, access bank or indexed literal offset
  always @*
  begin
    indexed_mode = 1'b0;
    if (access_sel)
      data_addr = {bank_select_register[3:0], file_addr};
    else if (ext_set_en && file_addr <= `BBE_ILO_LIMIT)
    begin
      // Offset is added to the index pointer
      indexed_mode = 1'b1;
      data_addr = index_base + {4'h0, file_addr};
    end
    else if (file_addr[7])
      data_addr = `BBE_ACC_SFR_BASE | {4'h0, file_addr};
    else
      data_addr = {4'h0, file_addr}; // Low access bank
  end
endmodule // bbe_addr_gen

// [logic/bbe_exec.v]
// Execution slice: carry/negative branches, bit clear, AND W with file
// What this block does
// - E2 opcode branches when carry is one
// - E6 opcode branches when negative is one
// - Target is branch address plus two plus 2n
// - Branch is one word, 1 or 2 cycles
// - Taken: decode, literal, process, write PC; then nop
// - Not taken: Q4 leaves PC untouched
// - 1001 bbba ffff ffff clears one bit
// - Access bit zero access bank, one uses bank select
// - Extended set, a zero, f up to 5Fh indexed
// - Bit clear is one-cycle read-modify-write
// - AND reads Q2, processes Q3, writes Q4
// - AND W with file sets only N and Z
// - Destination zero to W, one to file
`timescale 1ns/1ps
`include "bbe_regs.vh"
module bbe_exec
#(
  parameter PC_W = 21
)
(
  input wire mclk,
  input wire rst_n,
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire [PC_W-1:0] instr_pc,
  input wire carry_flag,
  input wire negative_flag,
  input wire [7:0] accumulator,
  input wire [5:0] bank_select_register,
  input wire ext_set_en,
  input wire [11:0] index_base,
  input wire [7:0] file_rdata,
  output reg [1:0] q_phase,
  output reg instr_ready,
  output reg [11:0] file_addr_out,
  output reg file_rd,
  output reg file_wr,
  output reg [7:0] file_wdata,
  output reg acc_wr,
  output reg [7:0] acc_wdata,
  output reg flags_wr,
  output reg flag_n,
  output reg flag_z,
  output reg pc_load,
  output reg [PC_W-1:0] pc_target,
  output reg flush_nop,
  output reg indexed_used
);
  // How one instruction cycle is laid out in this slice.
  //
  // The sequencer runs four core clocks per instruction cycle and the
  // phase counter never stops, so the fetch side always knows where the
  // next hand-over edge falls: the edge that leaves Q4.
  //
  // Q4 edge: the next word is latched into ir when instr_ready is high.
  // Q1 slot: decode only; the class was already worked out from the
  //          incoming word, so nothing is left to do here.
  // Q2 edge: the data address goes out and file_rd pulses in the Q3 slot.
  // Q3 edge: read data is captured and the branch condition is frozen.
  // Q4 edge: write strobes, flag strobe or program counter load.
  //
  // A taken branch adds a dead cycle.  The fetch side must throw away
  // the word it prefetched, so instr_ready stays low in the Q4 of the
  // branch itself and flush_nop stands over all four dead phases.
  //
  // Hazards and limits that a user of this slice should know:
  // - Status flags are sampled at the Q3 edge, not at decode.  A flag
  //   written by the previous instruction at its Q4 edge is therefore
  //   already settled when a following branch looks at it.
  // - The read data must be valid in the same clock as file_rd, in the Q3
  //   slot; a slower data memory would need a wait state that this
  //   slice does not offer.
  // - Only the low four bits of the bank select value reach the
  //   address; the two upper bits are kept for a wider memory map.
  // - Unknown words run as no operation rather than as a trap, which
  //   keeps the slice simple when neighbouring decoders own them.
  // - The bit-clear write back happens even if the chosen bit was
  //   already clear; memory sees the same write either way, which keeps
  //   the write timing independent of the data.
  //
  // Trade-off: the target address is worked out for every instruction
  // in Q3, even for ones that never branch.  One adder that always runs
  // is cheaper than a gated one and only its load strobe matters.
  // Instruction classes
  localparam CL_NONE = 3'h0;
  localparam CL_BR_C = 3'h1;
  localparam CL_BR_N = 3'h2;
  localparam CL_BCLR = 3'h3;
  localparam CL_ANDF = 3'h4;
  // Latched instruction and its class
  reg [15:0] ir;
  reg [PC_W-1:0] ir_pc;
  reg [2:0] cls;
  reg taken;
  // Set during the dead cycle after a taken branch
  reg nop_cycle;
  reg [7:0] operand;
  reg [7:0] result;
  wire [11:0] gen_addr;
  wire gen_indexed;
  reg [2:0] next_cls;
  wire [7:0] offset;
  wire [PC_W-1:0] offset_x2;
  wire cond;
  // One-hot mask of the bit to clear
  wire [7:0] clr_mask;
  genvar gi;
  assign offset = ir[7:0];
  // Sign extend and double the offset
  assign offset_x2 = {{(PC_W-9){offset[7]}}, offset, 1'b0};
  // Condition from the class
  assign cond = (cls == CL_BR_C) ? carry_flag :
                (cls == CL_BR_N) ? negative_flag : 1'b0;
  // Decode the incoming opcode word
  always @*
  begin
    next_cls = CL_NONE;
    if (instr_word[15:8] == `BBE_OP_BR_CARRY)
      next_cls = CL_BR_C;
    else if (instr_word[15:8] == `BBE_OP_BR_NEG)
      next_cls = CL_BR_N;
    else if (instr_word[`BBE_F_TOP4_HI:`BBE_F_TOP4_LO] == `BBE_OP_BIT_CLEAR)
      next_cls = CL_BCLR;
    else if (instr_word[15:10] == `BBE_OP_AND_FILE)
      next_cls = CL_ANDF;
  end
  // Address of the file operand
  bbe_addr_gen u_addr
  (
    .file_addr(ir[7:0]),
    .access_sel(ir[`BBE_F_ACCESS]),
    .bank_select_register(bank_select_register),
    .ext_set_en(ext_set_en),
    .index_base(index_base),
    .data_addr(gen_addr),
    .indexed_mode(gen_indexed)
  );
  // Instruction fetch handshake: ready in every Q4 except the Q4 of a taken branch
  always @*
  begin
    instr_ready = (q_phase == `BBE_Q4) && !(taken && !nop_cycle);
  end
  // Bit-clear mask, one compare per bit position
  // A compare per bit avoids a shifter and keeps the mask one-hot
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_mask
      // Index of this bit at the width of the field
      localparam [2:0] BIT_IDX = gi;
      // Set only when this bit is the chosen one
      assign clr_mask[gi] = (ir[`BBE_F_BIT_HI:`BBE_F_BIT_LO] == BIT_IDX);
    end
  endgenerate
  // Process step: bit clear or AND
  always @*
  begin
    if (cls == CL_BCLR)
      result = operand & ~clr_mask; // Only the chosen bit drops
    else
      result = operand & accumulator;
  end
  // Phase sequencer and per-phase actions
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_phase <= `BBE_Q1;
      ir <= 16'h0000;
      ir_pc <= {PC_W{1'b0}};
      cls <= CL_NONE;
      taken <= 1'b0;
      nop_cycle <= 1'b0;
      operand <= 8'h00;
      file_addr_out <= 12'h000;
      file_rd <= 1'b0;
      file_wr <= 1'b0;
      file_wdata <= 8'h00;
      acc_wr <= 1'b0;
      acc_wdata <= 8'h00;
      flags_wr <= 1'b0;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      pc_load <= 1'b0;
      pc_target <= {PC_W{1'b0}};
      flush_nop <= 1'b0;
      indexed_used <= 1'b0;
    end
    else
    begin
      // Strobes last one phase
      file_rd <= 1'b0;
      file_wr <= 1'b0;
      acc_wr <= 1'b0;
      flags_wr <= 1'b0;
      pc_load <= 1'b0;
      q_phase <= q_phase + 2'h1;
      case (q_phase)
        `BBE_Q1:
        begin
          // Decode phase; the word was captured at the last Q4 edge
        end
        `BBE_Q2:
        begin
          // Read register or literal
          if (!nop_cycle && (cls == CL_BCLR || cls == CL_ANDF))
          begin
            file_addr_out <= gen_addr;
            indexed_used <= gen_indexed;
            file_rd <= 1'b1;
          end
        end
        `BBE_Q3:
        begin
          // Process: capture data, resolve branch
          if (!nop_cycle)
          begin
            operand <= file_rdata;
            taken <= cond;
            pc_target <= ir_pc + `BBE_PC_STEP + offset_x2;
          end
        end
        `BBE_Q4:
        begin
          if (nop_cycle)
          begin
            // End of dead cycle
            nop_cycle <= 1'b0;
            taken <= 1'b0;
            flush_nop <= 1'b0;
          end
          else if (taken)
          begin
            pc_load <= 1'b1; // Write PC in Q4
            nop_cycle <= 1'b1; // Second cycle follows
            // Flag stands over all four dead phases
            flush_nop <= 1'b1;
          end
          // Not taken: PC left alone here
          if (!nop_cycle && cls == CL_BCLR)
          begin
            file_wdata <= result; // Write back
            file_wr <= 1'b1; // No flag update
          end
          if (!nop_cycle && cls == CL_ANDF)
          begin
            flags_wr <= 1'b1; // Only N and Z
            flag_n <= result[7];
            flag_z <= (result == 8'h00);
            if (ir[`BBE_F_DEST])
            begin
              file_wdata <= result; // Back to file
              file_wr <= 1'b1;
            end
            else
            begin
              acc_wdata <= result; // Into W
              acc_wr <= 1'b1;
            end
          end
          // Latch next instruction when this one ends
          if (instr_ready)
          begin
            ir <= instr_valid ? instr_word : 16'h0000;
            ir_pc <= instr_pc;
            cls <= instr_valid ? next_cls : CL_NONE;
            taken <= 1'b0;
          end
        end
        default:
        begin
          flush_nop <= 1'b0;
        end
      endcase
    end
  end
endmodule // bbe_exec

// [dv/bbe_exec_properties.sv]
// Port timing checks for the execution slice
`timescale 1ns/1ps
module bbe_exec_properties
(
  input wire mclk,
  input wire rst_n,
  input wire [1:0] q_phase,
  input wire instr_ready,
  input wire file_rd,
  input wire file_wr,
  input wire [7:0] file_wdata,
  input wire acc_wr,
  input wire [7:0] acc_wdata,
  input wire flags_wr,
  input wire flag_n,
  input wire flag_z,
  input wire pc_load,
  input wire flush_nop
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ready_in_q4_a: assert property (instr_ready |-> q_phase == 2'h3)
    else $error("ready outside Q4");
  read_in_q3_a: assert property (file_rd |-> q_phase == 2'h2)
    else $error("read outside Q3");
  write_after_read_a: assert property
    ((file_wr || acc_wr) |-> $past(file_rd, 2)) else $error("lone write");
  write_in_q1_a: assert property
    ((file_wr || acc_wr || pc_load) |-> q_phase == 2'h0) else $error("late");
  dead_cycle_a: assert property (pc_load |=> flush_nop [*3])
    else $error("no dead cycle");
  dead_quiet_a: assert property
    (flush_nop && !pc_load |-> !(file_rd || file_wr || acc_wr || flags_wr))
    else $error("strobe in dead cycle");
  branch_flags_a: assert property
    (pc_load |-> !(flags_wr || file_wr || acc_wr)) else $error("branch wrote");
  and_flags_a: assert property (flags_wr |-> file_wr != acc_wr &&
    flag_z == ((file_wr ? file_wdata : acc_wdata) == 8'h00) &&
    flag_n == (file_wr ? file_wdata[7] : acc_wdata[7])) else $error("bad N Z");
endmodule // bbe_exec_properties

// [dv/bbe_exec_test.sv]
// Directed bench for the execution slice
`timescale 1ns/1ps
module bbe_exec_test;
  reg mclk = 1'b0; // 20 MHz core clock
  reg rst_n = 1'b0; // Held low for four cycles
  reg instr_valid = 1'b0;
  reg [15:0] instr_word = 16'h0000; // Idle word decodes to nothing
  reg [20:0] instr_pc = 21'h000100; // Every branch sits here
  reg carry_flag = 1'b0, negative_flag = 1'b0, ext_set_en = 1'b0;
  reg [7:0] accumulator = 8'h00, file_rdata = 8'h00;
  reg [5:0] bank_select_register = 6'h03; // Bank three for a=1
  reg [11:0] index_base = 12'h100;
  wire [1:0] q_phase;
  wire instr_ready, file_rd, file_wr, acc_wr, flags_wr, flag_n, flag_z;
  wire pc_load, flush_nop, indexed_used;
  wire [11:0] file_addr_out;
  wire [7:0] file_wdata, acc_wdata;
  wire [20:0] pc_target;
  integer n_fail = 0, comparisons = 0, k;
  integer s_cyc; // Cycles from accept to the next accept
  integer s_fl; // Cycles with flush_nop high
  reg [3:0] s_st; // Strobes seen: pc_load, file_wr, acc_wr, flags_wr
  reg [1:0] s_nz;
  reg [7:0] s_data;
  reg [11:0] s_addr;
  reg [20:0] s_pc;
  always #25 mclk = ~mclk;
  bbe_exec dut (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_pc(instr_pc), .carry_flag(carry_flag),
    .negative_flag(negative_flag), .accumulator(accumulator),
    .bank_select_register(bank_select_register), .ext_set_en(ext_set_en),
    .index_base(index_base), .file_rdata(file_rdata), .q_phase(q_phase),
    .instr_ready(instr_ready), .file_addr_out(file_addr_out),
    .file_rd(file_rd), .file_wr(file_wr), .file_wdata(file_wdata),
    .acc_wr(acc_wr), .acc_wdata(acc_wdata), .flags_wr(flags_wr),
    .flag_n(flag_n), .flag_z(flag_z), .pc_load(pc_load),
    .pc_target(pc_target), .flush_nop(flush_nop), .indexed_used(indexed_used));
  // Print the counts and the verdict, then stop
  task give_verdict;
    begin
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Packed results are compared four-state, so X never matches
  task cmp(input [31:0] got, input [31:0] exp, input string what);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("mismatch %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Issue one word at a Q4 edge, then record twelve cycles of strobes;
  // writes land after the next Q4 edge, so watching stops well past it
  task exec(input [15:0] w, input [2:0] cne, input [15:0] ar);
    begin
      @(posedge mclk);
      instr_word <= w;
      instr_valid <= 1'b1;
      {carry_flag, negative_flag, ext_set_en} <= cne;
      {accumulator, file_rdata} <= ar;
      k = 0;
      @(negedge mclk);
      while (!(q_phase === 2'h3 && instr_ready === 1'b1) && k < 20)
      begin
        @(negedge mclk);
        k = k + 1;
      end
      if (k >= 20)
      begin
        n_fail = n_fail + 1;
        give_verdict;
      end
      @(posedge mclk);
      instr_word <= 16'h0000;
      s_st = 4'h0;
      s_cyc = 0;
      s_fl = 0;
      for (k = 1; k <= 12; k = k + 1)
      begin
        @(negedge mclk);
        if (s_cyc == 0 && q_phase === 2'h3 && instr_ready === 1'b1)
          s_cyc = k;
        s_st = s_st | {pc_load, file_wr, acc_wr, flags_wr};
        if (flush_nop === 1'b1)
          s_fl = s_fl + 1;
        if (pc_load === 1'b1)
          s_pc = pc_target;
        if (file_rd === 1'b1)
          s_addr = file_addr_out;
        if (file_wr === 1'b1)
          s_data = file_wdata;
        if (acc_wr === 1'b1)
          s_data = acc_wdata;
        if (flags_wr === 1'b1)
          s_nz = {flag_n, flag_z};
      end
    end
  endtask
  // Both branches taken and not, offsets at the signed limits
  task t_branch;
    begin
      exec(16'hE205, 3'h4, 16'h0000);
      cmp({s_st, s_pc, s_cyc[3:0]}, {4'h8, 21'h10C, 4'h8}, "c5");
      cmp(s_fl, 4, "flush");
      exec(16'hE280, 3'h4, 16'h0000);
      cmp({s_st, s_pc}, {4'h8, 21'h002}, "c-128");
      exec(16'hE27F, 3'h2, 16'h0000);
      cmp({s_st, s_cyc[3:0]}, {4'h0, 4'h4}, "c off");
      cmp(s_fl, 0, "no flush");
      exec(16'hE6FE, 3'h2, 16'h0000);
      cmp({s_st, s_pc, s_cyc[3:0]}, {4'h8, 21'h0FE, 4'h8}, "n-2");
      exec(16'hE67F, 3'h4, 16'h0000);
      cmp(s_st, 4'h0, "n off");
      $display("branch test done");
    end
  endtask
  // Bit clear through bank, access bank and indexed addressing
  task t_clear;
    begin
      exec(16'h9F34, 3'h0, 16'h00C7);
      cmp({s_st, s_addr, s_data}, {4'h4, 12'h334, 8'h47}, "b7");
      exec(16'h9080, 3'h0, 16'h00C7);
      cmp({s_addr, s_data, indexed_used},
        {12'hF80, 8'hC6, 1'b0}, "f80");
      exec(16'h945F, 3'h1, 16'h00C7);
      cmp({s_addr, s_data, indexed_used},
        {12'h15F, 8'hC3, 1'b1}, "5f");
      exec(16'h9060, 3'h1, 16'h00C7);
      // Low access half runs up to 7Fh in this slice
      cmp({s_st, s_addr, indexed_used},
        {4'h4, 12'h060, 1'b0}, "60");
      $display("bit clear test done");
    end
  endtask
  // AND to each destination, negative and zero results
  task t_and;
    begin
      exec(16'h1410, 3'h0, 16'h17C2);
      cmp({s_st, s_data, s_nz}, {4'h3, 8'h02, 2'h0}, "to w");
      exec(16'h1710, 3'h0, 16'hF08F);
      cmp({s_st, s_addr, s_data, s_nz},
        {4'h5, 12'h310, 8'h80, 2'h2}, "to f");
      exec(16'h1410, 3'h0, 16'h0FF0);
      cmp({s_st, s_data, s_nz}, {4'h3, 8'h00, 2'h1}, "zero");
      $display("and test done");
    end
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_branch;
    t_clear;
    t_and;
    give_verdict;
  end
endmodule // bbe_exec_test
bind bbe_exec bbe_exec_properties chk (.mclk(mclk), .rst_n(rst_n),
  .q_phase(q_phase), .instr_ready(instr_ready), .file_rd(file_rd),
  .file_wr(file_wr), .file_wdata(file_wdata), .acc_wr(acc_wr),
  .acc_wdata(acc_wdata), .flags_wr(flags_wr), .flag_n(flag_n),
  .flag_z(flag_z), .pc_load(pc_load), .flush_nop(flush_nop));
